// [common/inv_cmd_pkg.sv]
// Purpose: constants and carriers for the inverter command handler
// Assumes: 250 MHz controller clock, packets already deframed
// Notes:   parameter limits follow the host input ranges
// How it works
// [R1] switching frequency is whole kHz, valid 1 to 65
// [R2] modulation depth is factor times 1000, valid 0 to 1000
// [R3] blanking interval in ns between upper and lower switch, 100 to 2000
// [R4] output sine frequency in whole Hz, valid 1 to 500
// [R5] six supply-off and six logic-on bits, channels 1..6 map to U..Z
// [R6] fault-clear request resets all six gate drivers together
// [R7] every control packet is answered with echoed parameters and states
// [R8] response also carries present per-channel driver fault status
// [R9] feedback sent about once per second, independent of control traffic
// [R10] feedback: six phase temps, currents, voltages plus ambient and bus
// [R11] status indicator toggles once per received host packet; a control and an other packet in the same cycle give one toggle
// [R12] any driver fault clears all six logic-on bits and is reported
// [R13] out-of-range parameters clamp to nearest limit, clamped value echoed
package inv_cmd_pkg;

  // ****************************************************
  // parameter limits
  // ****************************************************
  localparam logic [15:0] SW_FREQ_MIN    = 16'h0001;
  localparam logic [15:0] SW_FREQ_MAX    = 16'h0041;
  localparam logic [15:0] MOD_DEPTH_MIN  = 16'h0000;
  localparam logic [15:0] MOD_DEPTH_MAX  = 16'h03E8;
  localparam logic [15:0] BLANK_NS_MIN   = 16'h0064;
  localparam logic [15:0] BLANK_NS_MAX   = 16'h07D0;
  localparam logic [15:0] OUT_FREQ_MIN   = 16'h0001;
  localparam logic [15:0] OUT_FREQ_MAX   = 16'h01F4;

  // ****************************************************
  // reset values and timing
  // ****************************************************
  localparam logic [15:0] SW_FREQ_RST    = 16'h0001;
  localparam logic [15:0] MOD_DEPTH_RST  = 16'h0000;
  localparam logic [15:0] BLANK_NS_RST   = 16'h07D0;
  localparam logic [15:0] OUT_FREQ_RST   = 16'h0001;
  localparam logic [5:0]  SUPPLY_OFF_RST = 6'h00;
  localparam logic [5:0]  LOGIC_ON_RST   = 6'h00;
  localparam int          CLK_HZ         = 250_000_000;
  localparam int          FEEDBACK_S     = 1;
  localparam int          FEEDBACK_CYC   = CLK_HZ * FEEDBACK_S;
  localparam logic [27:0] FB_CNT_RST     = 28'h000_0000;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [15:0] sw_freq_khz;
    logic [15:0] mod_depth;
    logic [15:0] blank_ns;
    logic [15:0] out_freq_hz;
  } pwm_params_t;

  typedef struct packed {
    pwm_params_t params;
    logic [5:0]  supply_off;
    logic [5:0]  logic_on;
    logic        fault_clear;
  } ctrl_pkt_t;

  typedef struct packed {
    pwm_params_t params;
    logic [5:0]  supply_off;
    logic [5:0]  logic_on;
    logic [5:0]  fault;
  } resp_pkt_t;

  typedef struct packed {
    logic [5:0][15:0] temp_c;
    logic [5:0][15:0] current_a;
    logic [5:0][15:0] voltage_v;
    logic [15:0]      ambient_c;
    logic [15:0]      dc_bus_voltage;
  } feedback_t;

endpackage : inv_cmd_pkg

// [hw/inverter_can_command_handler.sv]
// Purpose: take control packets, drive gate-driver controls, answer, report
// Assumes: packet strobes are one-cycle pulses from same-clock logic
// Notes:   fault pins are asynchronous and pass a two-stage synchroniser
module inverter_can_command_handler
  import inv_cmd_pkg::*;
#(
  parameter int FEEDBACK_PERIOD = FEEDBACK_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // host packets in
  input  wire logic        ctrl_valid_in,
  input  wire ctrl_pkt_t   ctrl_pkt_in,
  input  wire logic        other_pkt_in,
  // gate drivers
  input  wire logic [5:0]  driver_fault_in,
  output logic [5:0]       supply_off_out,
  output logic [5:0]       logic_on_out,
  output logic             driver_reset_out,
  // pwm parameters in use
  output pwm_params_t      params_out,
  // measurements
  input  wire feedback_t   measure_in,
  // answers
  output logic             resp_valid_out,
  output resp_pkt_t        resp_pkt_out,
  output logic             feedback_valid_out,
  output feedback_t        feedback_out,
  // indicator
  output logic             status_led_out
);

  // ****************************************************
  // clamping
  // ****************************************************
  logic [15:0] sw_freq_lim;
  logic [15:0] mod_depth_lim;
  logic [15:0] blank_lim;
  logic [15:0] out_freq_lim;
  pwm_params_t clamped;

  param_clamp #(
    .LO (SW_FREQ_MIN),
    .HI (SW_FREQ_MAX)
  ) i_clamp_sw_freq (
    .value_in  (ctrl_pkt_in.params.sw_freq_khz),
    .value_out (sw_freq_lim)
  ); // [R1] [R13]

  param_clamp #(
    .LO (MOD_DEPTH_MIN),
    .HI (MOD_DEPTH_MAX)
  ) i_clamp_mod_depth (
    .value_in  (ctrl_pkt_in.params.mod_depth),
    .value_out (mod_depth_lim)
  ); // [R2] [R13]

  param_clamp #(
    .LO (BLANK_NS_MIN),
    .HI (BLANK_NS_MAX)
  ) i_clamp_blank (
    .value_in  (ctrl_pkt_in.params.blank_ns),
    .value_out (blank_lim)
  ); // [R3] [R13]

  param_clamp #(
    .LO (OUT_FREQ_MIN),
    .HI (OUT_FREQ_MAX)
  ) i_clamp_out_freq (
    .value_in  (ctrl_pkt_in.params.out_freq_hz),
    .value_out (out_freq_lim)
  ); // [R4] [R13]

  assign clamped = {sw_freq_lim, mod_depth_lim, blank_lim, out_freq_lim};

  // ****************************************************
  // gate-driver channels and fault synchronisers
  // ****************************************************
  // the pins are asynchronous; each channel carries its own two-stage
  // synchroniser and only the second stage feeds any logic
  logic [5:0] fault_sync;
  wire        any_fault = |fault_sync;

  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++) begin : g_channel
      driver_channel #(
        .CH (ch)
      ) i_channel (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .ctrl_valid_in  (ctrl_valid_in),
        .supply_off_in  (ctrl_pkt_in.supply_off[ch]),
        .logic_on_in    (ctrl_pkt_in.logic_on[ch]),
        .fault_pin_in   (driver_fault_in[ch]),
        .any_fault_in   (any_fault),
        .fault_sync_out (fault_sync[ch]),
        .supply_off_out (supply_off_out[ch]),
        .logic_on_out   (logic_on_out[ch])
      ); // [R5] [R12]
    end
  endgenerate

  // ****************************************************
  // parameters in use
  // ****************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      params_out.sw_freq_khz <= SW_FREQ_RST;
      params_out.mod_depth   <= MOD_DEPTH_RST;
      params_out.blank_ns    <= BLANK_NS_RST;
      params_out.out_freq_hz <= OUT_FREQ_RST;
    end else if (ctrl_valid_in) begin
      params_out <= clamped; // [R13]
    end
  end

  // ****************************************************
  // gate-driver controls
  // ****************************************************
  // bit 0 is phase U through bit 5 phase Z; the channels above hold the
  // per-channel controls, this reset pulse serves all six at once

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      driver_reset_out <= 1'b0;
    end else begin
      driver_reset_out <= ctrl_valid_in & ctrl_pkt_in.fault_clear; // [R6]
    end
  end

  // ****************************************************
  // response
  // ****************************************************
  // echo built from the same next values that the controls take, so the
  // response shows exactly what went into use on that edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      resp_valid_out <= 1'b0;
      resp_pkt_out   <= '0;
    end else begin
      resp_valid_out <= ctrl_valid_in; // [R7]
      if (ctrl_valid_in) begin
        resp_pkt_out.params     <= clamped; // [R7] [R13]
        resp_pkt_out.supply_off <= ctrl_pkt_in.supply_off; // [R7]
        resp_pkt_out.logic_on   <= any_fault ? 6'h00
                                             : ctrl_pkt_in.logic_on; // [R12]
        resp_pkt_out.fault      <= fault_sync; // [R8]
      end
    end
  end

  // ****************************************************
  // periodic feedback
  // ****************************************************
  logic fb_due;

  period_timer #(
    .PERIOD (FEEDBACK_PERIOD)
  ) i_feedback_timer (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .due_out  (fb_due)
  ); // [R9]

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      feedback_valid_out <= 1'b0;
      feedback_out       <= '0;
    end else begin
      feedback_valid_out <= fb_due; // [R9]
      if (fb_due) begin
        feedback_out <= measure_in; // [R10]
      end
    end
  end

  // ****************************************************
  // status indicator
  // ****************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_led_out <= 1'b0;
    end else if (ctrl_valid_in | other_pkt_in) begin
      status_led_out <= ~status_led_out; // [R11]
    end
  end

endmodule : inverter_can_command_handler

// ****************************************************
// range clamp for one 16-bit parameter
// ****************************************************
module param_clamp #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  // raw value from the packet
  input  wire logic [15:0] value_in,
  // value limited to the legal range
  output logic [15:0]      value_out
);

  // a limit is used instead of refusing the packet, so a slip on the
  // host side never leaves the modulator without parameters
  always_comb begin
    value_out = value_in;
    if (value_in < LO) begin
      value_out = LO; // [R13]
    end else if (value_in > HI) begin
      value_out = HI; // [R13]
    end
  end

endmodule : param_clamp

// ****************************************************
// one gate-driver channel
// ****************************************************
module driver_channel
  import inv_cmd_pkg::*;
#(
  parameter int CH = 0
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // packet controls for this channel
  input  wire logic ctrl_valid_in,
  input  wire logic supply_off_in,
  input  wire logic logic_on_in,
  // fault pin of this channel and summary of all channels
  input  wire logic fault_pin_in,
  input  wire logic any_fault_in,
  // synchronised fault and driver controls
  output logic      fault_sync_out,
  output logic      supply_off_out,
  output logic      logic_on_out
);

  logic fault_meta_reg;

  // only the second stage is read, the first may be metastable
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fault_meta_reg <= 1'b0;
      fault_sync_out <= 1'b0;
    end else begin
      fault_meta_reg <= fault_pin_in;
      fault_sync_out <= fault_meta_reg;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      supply_off_out <= SUPPLY_OFF_RST[CH];
    end else if (ctrl_valid_in) begin
      supply_off_out <= supply_off_in; // [R5]
    end
  end

  // a fault wins over a logic-on request in the same cycle so a faulted
  // driver is never re-enabled before the fault is cleared
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      logic_on_out <= LOGIC_ON_RST[CH];
    end else if (any_fault_in) begin
      logic_on_out <= 1'b0; // [R12]
    end else if (ctrl_valid_in) begin
      logic_on_out <= logic_on_in; // [R5]
    end
  end

endmodule : driver_channel

// ****************************************************
// free-running period timer
// ****************************************************
// counts on its own so feedback never waits on packets or the pwm loop
module period_timer
  import inv_cmd_pkg::*;
#(
  parameter int PERIOD = FEEDBACK_CYC
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // high in the last cycle of each period
  output logic      due_out
);

  logic [27:0] cnt_reg;

  // 28 bits hold a one-second period at the controller clock; a longer
  // period would wrap early
  assign due_out = (cnt_reg == 28'(PERIOD - 1));

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= FB_CNT_RST;
    end else if (due_out) begin
      cnt_reg <= FB_CNT_RST; // [R9]
    end else begin
      cnt_reg <= cnt_reg + 28'h000_0001; // [R9]
    end
  end

endmodule : period_timer

// [bench/handler_properties.sv]
// Purpose: port assertions for the command handler
// Assumes: one clock, async active-high reset
// Notes:   bound to every handler instance
module handler_properties
  import inv_cmd_pkg::*;
#(parameter int FEEDBACK_PERIOD = 16) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ctrl_valid_in,
  input wire ctrl_pkt_t ctrl_pkt_in,
  input wire logic other_pkt_in,
  input wire logic [5:0] driver_fault_in,
  input wire logic [5:0] supply_off_out,
  input wire logic [5:0] logic_on_out,
  input wire logic driver_reset_out,
  input wire pwm_params_t params_out,
  input wire feedback_t measure_in,
  input wire logic resp_valid_out,
  input wire resp_pkt_t resp_pkt_out,
  input wire logic feedback_valid_out,
  input wire feedback_t feedback_out,
  input wire logic status_led_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [27:0] gap_reg;
  // a counter, since a repetition this long would not unroll
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) gap_reg <= 28'h0;
    else gap_reg <= feedback_valid_out ? 28'h1 : gap_reg + 28'h1;
  end
  sequence fault_held;
    (|driver_fault_in) [*3];
  endsequence
  resp_next_a: assert property (resp_valid_out == $past(ctrl_valid_in))
    else $error("response timing");
  clear_pulse_a: assert property (driver_reset_out ==
    $past(ctrl_valid_in && ctrl_pkt_in.fault_clear)) else $error("reset pulse");
  supply_map_a: assert property (ctrl_valid_in |=>
    supply_off_out == $past(ctrl_pkt_in.supply_off)) else $error("supply");
  echo_params_a: assert property (ctrl_valid_in |=>
    resp_pkt_out.params == params_out) else $error("echo");
  resp_fault_a: assert property (ctrl_valid_in |=>
    resp_pkt_out.fault == $past(driver_fault_in, 3)) else $error("fault echo");
  params_range_a: assert property (
    params_out.mod_depth <= 16'h03e8 &&
    params_out.sw_freq_khz inside {[16'h0001:16'h0041]} &&
    params_out.blank_ns inside {[16'h0064:16'h07d0]} &&
    params_out.out_freq_hz inside {[16'h0001:16'h01f4]}) else $error("range");
  led_toggle_a: assert property (
    $changed(status_led_out) == $past(ctrl_valid_in || other_pkt_in))
    else $error("indicator");
  fault_off_a: assert property (fault_held |=> logic_on_out == 6'h00)
    else $error("logic on kept");
  fb_period_a: assert property (
    feedback_valid_out == (gap_reg == 28'(FEEDBACK_PERIOD))) else $error("period");
  fb_sample_a: assert property (feedback_valid_out |->
    feedback_out == $past(measure_in)) else $error("feedback data");
endmodule : handler_properties

bind inverter_can_command_handler handler_properties
  #(.FEEDBACK_PERIOD(FEEDBACK_PERIOD)) i_props (.*);

// [bench/host_model.sv]
// Purpose: host application side of the packet link
// Assumes: each call starts just after a rising edge
// Notes:   a control packet and an other packet may arrive in the same cycle
module host_model
  import inv_cmd_pkg::*;
(
  input  wire logic clk_in,
  output logic      ctrl_valid_out,
  output ctrl_pkt_t ctrl_pkt_out,
  output logic      other_pkt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ctrl_valid_out = 1'b0;
    ctrl_pkt_out = '0;
    other_pkt_out = 1'b0;
  end
  task automatic send(input ctrl_pkt_t p, input logic v, input logic o);
    ctrl_pkt_out = p;
    ctrl_valid_out = v;
    other_pkt_out = o;
    @(posedge clk_in);
    #1;
  endtask : send
  // released bus shows the inverse, never a stale packet
  task automatic idle();
    ctrl_valid_out = 1'b0;
    other_pkt_out = 1'b0;
    ctrl_pkt_out = ~ctrl_pkt_out;
  endtask : idle
endmodule : host_model

// [bench/test_inverter_can_command_handler.sv]
// Purpose: self-checking bench for the command handler
// Assumes: feedback period cut to 16 cycles
// Notes:   expected responses queue up as packets go out
module test_inverter_can_command_handler import inv_cmd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, reset_in, ctrl_valid_in, other_pkt_in, driver_reset_out;
  logic resp_valid_out, feedback_valid_out, status_led_out, led_exp;
  logic [5:0] driver_fault_in, supply_off_out, logic_on_out;
  ctrl_pkt_t ctrl_pkt_in;
  pwm_params_t params_out;
  resp_pkt_t resp_pkt_out;
  feedback_t measure_in, feedback_out;
  int errors = 0, n_checks = 0, cycles = 0, seed = 32'h0c73_307c;
  logic [83:0] exp_q[$];
  logic [15:0] edge_v[12] = '{16'h0000, 16'h0001, 16'h0041, 16'h0042, 16'h0064,
    16'h01f4, 16'h01f5, 16'h03e8, 16'h03e9, 16'h07d0, 16'h07d1, 16'hffff};
  host_model i_host (.clk_in(clk_in), .ctrl_valid_out(ctrl_valid_in),
    .ctrl_pkt_out(ctrl_pkt_in), .other_pkt_out(other_pkt_in));
  inverter_can_command_handler #(.FEEDBACK_PERIOD(16)) i_dut (.*);
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic check(input logic [319:0] seen, input logic [319:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  function automatic logic [15:0] lim(input int v, input int lo, input int hi);
    return 16'(v < lo ? lo : (v > hi ? hi : v));
  endfunction : lim
  function automatic ctrl_pkt_t rnd();
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    return r[76:0];
  endfunction : rnd
  task automatic tx(input ctrl_pkt_t p, input logic v, input logic o);
    resp_pkt_t e;
    e.params = {lim(p.params.sw_freq_khz, 1, 65), lim(p.params.mod_depth, 0,
      1000), lim(p.params.blank_ns, 100, 2000), lim(p.params.out_freq_hz, 1,
      500)};
    e.supply_off = p.supply_off;
    e.logic_on = (driver_fault_in != 6'h00) ? 6'h00 : p.logic_on;
    e.fault = driver_fault_in;
    if (v | o) led_exp = ~led_exp;
    if (v) exp_q.push_back({e, led_exp, p.fault_clear});
    i_host.send(p, v, o);
  endtask : tx
  always @(negedge clk_in) begin : monitor
    logic [83:0] x;
    if (resp_valid_out === 1'b1) begin
      x = (exp_q.size() > 0) ? exp_q.pop_front() : 84'h0;
      check({resp_pkt_out, status_led_out, driver_reset_out,
        params_out, supply_off_out, logic_on_out},
        {x, x[83:8]});
    end
    if (feedback_valid_out === 1'b1) check(feedback_out, measure_in);
    cycles++;
    if (cycles > 2000) begin
      errors++;
      results();
    end
  end
  initial begin : main
    ctrl_pkt_t p;
    reset_in = 1'b1;
    driver_fault_in = 6'h00;
    measure_in = '0;
    led_exp = 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    check({params_out, logic_on_out, status_led_out},
      {16'h0001, 16'h0000, 16'h07d0, 16'h0001, 7'h00});
    foreach (edge_v[k]) begin
      p = rnd();
      p.params = {4{edge_v[k]}};
      tx(p, 1'b1, 1'b0);
    end
    repeat (40) begin
      p = rnd();
      tx(p, 1'($random(seed)), 1'($random(seed)));
    end
    i_host.idle();
    p = rnd();
    p.logic_on = 6'h3f;
    tx(p, 1'b1, 1'b0);
    i_host.idle();
    driver_fault_in = 6'($random(seed)) | 6'h01;
    repeat (4) @(posedge clk_in);
    #1;
    check(logic_on_out, 6'h00);
    p.fault_clear = 1'b1;
    tx(p, 1'b1, 1'b0);
    i_host.idle();
    driver_fault_in = 6'h00;
    repeat (4) @(posedge clk_in);
    #1;
    tx(p, 1'b1, 1'b0);
    i_host.idle();
    repeat (3) begin
      @(posedge clk_in iff feedback_valid_out === 1'b1);
      #1;
      for (int i = 0; i < 10; i++) measure_in[i*32 +: 32] = $random(seed);
    end
    check(exp_q.size(), 0);
    results();
  end
endmodule : test_inverter_can_command_handler
